// ---- umci_pkg.sv ----
// constants, field positions and carrier types of the modem control and interrupt id block
package umci_pkg;

	// ------------------------------------------------------------
	// register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MLC = 8'h00;
	localparam logic [7:0] OFS_MLS = 8'h04;
	localparam logic [7:0] OFS_IEM = 8'h08;
	localparam logic [7:0] OFS_ISI = 8'h0c;
	localparam logic [7:0] OFS_EFC = 8'h10;
	localparam logic [7:0] OFS_QCTL = 8'h14;
	localparam logic [7:0] OFS_THRESH = 8'h18;
	localparam logic [7:0] OFS_TRIG = 8'h1c;
	localparam logic [7:0] OFS_DIVISOR = 8'h20;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MLC_DTR = 0;
	localparam int MLC_RTS = 1;
	localparam int MLC_QRDY = 2;
	localparam int MLC_IRQEN = 3;
	localparam int MLC_LOOP = 4;
	localparam int MLC_XANY = 5;
	localparam int MLC_TACC = 6;
	localparam int MLC_DIV4 = 7;
	localparam int IEM_RX = 0;
	localparam int IEM_TX = 1;
	localparam int IEM_LS = 2;
	localparam int IEM_MS = 3;
	localparam int IEM_SLEEP = 4;
	localparam int IEM_XOFF = 5;
	localparam int IEM_RTS = 6;
	localparam int IEM_CTS = 7;
	localparam int EFC_ENH = 4;
	localparam int QCTL_EN = 0;

	// ------------------------------------------------------------
	// identification codes on bits 5..0, reset values
	// ------------------------------------------------------------
	localparam logic [5:0] ID_LS = 6'h06;
	localparam logic [5:0] ID_RXTO = 6'h0c;
	localparam logic [5:0] ID_RX = 6'h04;
	localparam logic [5:0] ID_TX = 6'h02;
	localparam logic [5:0] ID_MS = 6'h08;
	localparam logic [5:0] ID_XOFF = 6'h10;
	localparam logic [5:0] ID_CR = 6'h20;
	localparam logic [5:0] ID_NONE = 6'h01;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_DIVISOR = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_RDWAIT = 2'b10
	} umci_bus_e;

	// events from the rest of the channel
	typedef struct packed {
		logic line_err;
		logic rx_timeout;
		logic rx_avail;
		logic tx_below;
		logic xoff_det;
	} umci_evt_s;

	// configuration handed to the rest of the channel
	typedef struct packed {
		logic loopback;
		logic xon_any;
		logic sleep_en;
		logic queue_ready_en;
		logic thresh_access;
		logic fifo_en;
		logic [7:0] thresh;
		logic [7:0] trig;
		logic [15:0] divisor;
	} umci_cfg_s;

	typedef struct packed {
		umci_bus_e bus;
		logic wr_pend;
		logic [7:0] wr_adr;
		logic [7:0] rd_adr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic [7:0] mlc;
		logic [7:0] mls;
		logic [7:0] iem;
		logic [7:0] efc;
		logic [7:0] qctl;
		logic [7:0] thresh;
		logic [7:0] trig;
		logic [15:0] divisor;
		logic thr_pend;
		logic tx_below_prev;
		logic xoff_flag;
		logic cts_flag;
		logic rts_flag;
		logic strap_done;
		logic [3:0] divcnt;
		logic tick;
		logic dtr_b;
		logic rts_b;
		logic irq;
		logic rx_serial;
	} umci_state_s;

endpackage

// ---- umci_core.sv ----
// modem control, modem status, interrupt enable and interrupt identification of one uart channel
`timescale 1ns/1ps

// How it works
// - control bit 0 drives dtr_b low when set; loopback feeds status bit 5 instead.
// - control bit 1 drives rts_b low; loopback feeds status bit 4; auto rts overrides.
// - control bit 2 enables the combined queue ready register; loopback feeds status bit 6.
// - control bit 3 enables the interrupt output driver; loopback feeds status bit 7.
// - control bit 4 loops control bits 3..0 into status and serial out into serial in.
// - control bit 5 enables the xon-any function.
// - control bit 6 opens access to threshold and trigger level registers.
// - control bit 7 selects divide by four; starts as inverse of select pin.
// - control bits 7..5 and enable bits 7..4 written only with enhanced bit set.
// - status bits 0,1,3 flag changes; bit 2 flags ring end; read clears.
// - status bits 7..4 show inverted pins, or control bits in loopback.
// - enable bits 0..3 enable receive, transmit, line status and modem interrupts.
// - enable bit 4 enables sleep mode.
// - enable bits 5..7 enable xoff, rts rising and cts rising interrupts.
// - re-enabling transmit interrupt while below threshold raises a new one.
// - identification is read only; bit 0 low while an enabled interrupt pends.
// - identification bits 7 and 6 mirror the queue enable bit.
// - line status error has top priority, code 000110.
// - then timeout/receive, transmit, modem, xoff codes by level 2 to 5.
// - cts or rts rising is lowest priority, code 100000.
// - identification bit 4 means xoff, bit 5 means cts/rts rising.
// - interrupt output asserts whenever any enabled source pends.
// - threshold and trigger writes need enhanced bit and control bit 6.
// - divisor writes are taken only while sleep enable is clear.
module umci_core
	import umci_pkg::*;
#(
	parameter int DIV_SLOW = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cts_b,
	input wire logic dsr_b,
	input wire logic ri_b,
	input wire logic cd_b,
	output logic dtr_b,
	output logic rts_b,
	input wire logic auto_rts_en,
	input wire logic hw_rts_b,
	input wire logic clock_divide_select_pin,
	input wire logic tx_serial,
	input wire logic rx_pin,
	output logic rx_serial,
	input wire umci_evt_s evt,
	output umci_cfg_s cfg,
	output logic irq,
	output logic irq_oe,
	output logic tick_en
);

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (DIV_SLOW < 2 || DIV_SLOW > 16) begin : g_bad_div
		$error("DIV_SLOW must lie in 2..16");
	end
	localparam logic [3:0] DIV_LAST = 4'(DIV_SLOW - 1);

	// priority encoder of the identification code
	function automatic logic [5:0] id_code(input logic ls, input logic to, input logic rx, input logic tx,
		input logic ms, input logic xo, input logic cr);
		if (ls) begin
			return ID_LS;
		end else if (to) begin
			return ID_RXTO;
		end else if (rx) begin
			return ID_RX;
		end else if (tx) begin
			return ID_TX;
		end else if (ms) begin
			return ID_MS;
		end else if (xo) begin
			return ID_XOFF;
		end else if (cr) begin
			return ID_CR;
		end
		return ID_NONE;
	endfunction

	umci_state_s q;
	umci_state_s d;
	logic [3:0] cur_hi;
	logic [3:0] set_delta;
	logic [7:0] wb;
	logic src_ls, src_to, src_rx, src_tx, src_ms, src_xo, src_cr;
	logic any_pend;
	logic [5:0] id_now;
	logic [7:0] id_byte;
	logic take;
	logic rd_now;
	logic enh;

	// ------------------------------------------------------------
	// enabled interrupt sources
	// ------------------------------------------------------------
	assign src_ls = q.iem[IEM_LS] & evt.line_err;
	assign src_to = q.iem[IEM_RX] & evt.rx_timeout;
	assign src_rx = q.iem[IEM_RX] & evt.rx_avail;
	assign src_tx = q.iem[IEM_TX] & q.thr_pend;
	assign src_ms = q.iem[IEM_MS] & (|q.mls[3:0]);
	assign src_xo = q.iem[IEM_XOFF] & q.xoff_flag;
	assign src_cr = (q.iem[IEM_RTS] & q.rts_flag) | (q.iem[IEM_CTS] & q.cts_flag);
	assign any_pend = src_ls | src_to | src_rx | src_tx | src_ms | src_xo | src_cr;
	assign id_now = id_code(src_ls, src_to, src_rx, src_tx, src_ms, src_xo, src_cr);
	assign id_byte = {q.qctl[QCTL_EN], q.qctl[QCTL_EN], id_now};
	assign take = hsel & hready & htrans[1];
	assign rd_now = (q.bus == BUS_RDWAIT);
	assign enh = q.efc[EFC_ENH];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// reads take one wait state so that a write in its data phase lands first
	always_comb begin
		d = q;
		wb = hwdata[7:0];
		// status lines: pins inverted, or control bits in loopback
		if (q.mlc[MLC_LOOP]) begin
			cur_hi = {q.mlc[MLC_IRQEN], q.mlc[MLC_QRDY], q.mlc[MLC_DTR], q.mlc[MLC_RTS]};
		end else begin
			cur_hi = {~cd_b, ~ri_b, ~dsr_b, ~cts_b};
		end
		// ring flags only when its status bit falls, i.e. the pin returns high
		set_delta = {cur_hi[3] ^ q.mls[7], q.mls[6] & ~cur_hi[2], cur_hi[1] ^ q.mls[5],
			cur_hi[0] ^ q.mls[4]};
		d.mls[7:4] = cur_hi;

		// bus address phase
		d.wr_pend = 1'b0;
		d.hreadyout = 1'b1;
		if (q.bus == BUS_IDLE && take) begin
			if (hwrite) begin
				d.wr_pend = 1'b1;
				d.wr_adr = haddr[7:0];
			end else begin
				d.bus = BUS_RDWAIT;
				d.rd_adr = haddr[7:0];
				d.hreadyout = 1'b0;
			end
		end

		// transmit interrupt follows the rising edge of below-threshold
		d.tx_below_prev = evt.tx_below;
		if (!evt.tx_below) begin
			d.thr_pend = 1'b0;
		end
		if (rd_now && q.rd_adr == OFS_ISI && id_now == ID_TX) begin
			d.thr_pend = 1'b0;
		end
		if (rd_now && q.rd_adr == OFS_ISI && id_now == ID_XOFF) begin
			d.xoff_flag = 1'b0;
		end
		if (rd_now && q.rd_adr == OFS_ISI && id_now == ID_CR) begin
			d.cts_flag = 1'b0;
			d.rts_flag = 1'b0;
		end

		// read data phase
		if (rd_now) begin
			d.bus = BUS_IDLE;
			d.hrdata = RST_WORD;
			case (q.rd_adr)
				OFS_MLC: d.hrdata[7:0] = q.mlc;
				OFS_MLS: begin
					d.hrdata[7:0] = q.mls;
					d.mls[3:0] = 4'h0;
				end
				OFS_IEM: d.hrdata[7:0] = q.iem;
				OFS_ISI: d.hrdata[7:0] = id_byte;
				OFS_EFC: d.hrdata[7:0] = q.efc;
				OFS_QCTL: d.hrdata[7:0] = q.qctl;
				OFS_THRESH: d.hrdata[7:0] = q.thresh;
				OFS_TRIG: d.hrdata[7:0] = q.trig;
				OFS_DIVISOR: d.hrdata[15:0] = q.divisor;
				default: d.hrdata = RST_WORD;
			endcase
		end
		// fresh changes win over the clear of a read
		d.mls[3:0] = d.mls[3:0] | set_delta;

		// write data phase
		if (q.wr_pend) begin
			case (q.wr_adr)
				OFS_MLC: begin
					d.mlc[4:0] = wb[4:0];
					if (enh) begin
						d.mlc[7:5] = wb[7:5];
					end
				end
				OFS_IEM: begin
					d.iem[3:0] = wb[3:0];
					if (enh) begin
						d.iem[7:4] = wb[7:4];
					end
					if (!q.iem[IEM_TX] && wb[IEM_TX] && evt.tx_below) begin
						d.thr_pend = 1'b1;
					end
				end
				OFS_EFC: d.efc = wb;
				OFS_QCTL: d.qctl[QCTL_EN] = wb[QCTL_EN];
				OFS_THRESH: begin
					if (enh && q.mlc[MLC_TACC]) begin
						d.thresh = wb;
					end
				end
				OFS_TRIG: begin
					if (enh && q.mlc[MLC_TACC]) begin
						d.trig = wb;
					end
				end
				OFS_DIVISOR: begin
					if (!q.iem[IEM_SLEEP]) begin
						d.divisor = hwdata[15:0];
					end
				end
				default: d.efc = q.efc;
			endcase
		end

		// event flags set after the clears, so a coincident event is kept
		if (evt.tx_below && !q.tx_below_prev) begin
			d.thr_pend = 1'b1;
		end
		if (evt.xoff_det) begin
			d.xoff_flag = 1'b1;
		end
		if (q.mls[4] && !cur_hi[0]) begin
			d.cts_flag = 1'b1;
		end

		// clock select caught once, right after reset release
		if (!q.strap_done) begin
			d.strap_done = 1'b1;
			d.mlc[MLC_DIV4] = ~clock_divide_select_pin;
		end

		// input clock enable: every cycle, or one in DIV_SLOW
		if (q.mlc[MLC_DIV4]) begin
			d.divcnt = (q.divcnt == DIV_LAST) ? 4'h0 : q.divcnt + 4'h1;
			d.tick = (q.divcnt == DIV_LAST);
		end else begin
			d.divcnt = 4'h0;
			d.tick = 1'b1;
		end

		// modem outputs go inactive in loopback; auto rts takes the pin over
		d.dtr_b = ~(d.mlc[MLC_DTR] & ~d.mlc[MLC_LOOP]);
		if (d.mlc[MLC_LOOP]) begin
			d.rts_b = 1'b1;
		end else if (auto_rts_en) begin
			d.rts_b = hw_rts_b;
		end else begin
			d.rts_b = ~d.mlc[MLC_RTS];
		end
		if (!q.rts_b && d.rts_b) begin
			d.rts_flag = 1'b1;
		end
		d.rx_serial = q.mlc[MLC_LOOP] ? tx_serial : rx_pin;
		d.irq = any_pend;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q.bus <= BUS_IDLE;
			q.wr_pend <= 1'b0;
			q.wr_adr <= RST_BYTE;
			q.rd_adr <= RST_BYTE;
			q.hreadyout <= 1'b1;
			q.hrdata <= RST_WORD;
			q.mlc <= RST_BYTE;
			q.mls <= RST_BYTE;
			q.iem <= RST_BYTE;
			q.efc <= RST_BYTE;
			q.qctl <= RST_BYTE;
			q.thresh <= RST_BYTE;
			q.trig <= RST_BYTE;
			q.divisor <= RST_DIVISOR;
			q.thr_pend <= 1'b0;
			q.tx_below_prev <= 1'b0;
			q.xoff_flag <= 1'b0;
			q.cts_flag <= 1'b0;
			q.rts_flag <= 1'b0;
			q.strap_done <= 1'b0;
			q.divcnt <= 4'h0;
			q.tick <= 1'b0;
			q.dtr_b <= 1'b1;
			q.rts_b <= 1'b1;
			q.irq <= 1'b0;
			q.rx_serial <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs, straight from the state register except hresp, which is tied low
	// ------------------------------------------------------------
	assign hreadyout = q.hreadyout;
	assign hresp = 1'b0;
	assign hrdata = q.hrdata;
	assign dtr_b = q.dtr_b;
	assign rts_b = q.rts_b;
	assign rx_serial = q.rx_serial;
	assign irq = q.irq;
	assign irq_oe = q.mlc[MLC_IRQEN];
	assign tick_en = q.tick;
	assign cfg = '{loopback: q.mlc[MLC_LOOP], xon_any: q.mlc[MLC_XANY], sleep_en: q.iem[IEM_SLEEP],
		queue_ready_en: q.mlc[MLC_QRDY], thresh_access: q.mlc[MLC_TACC], fifo_en: q.qctl[QCTL_EN],
		thresh: q.thresh, trig: q.trig, divisor: q.divisor};

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_rd_addr;
		q.bus == BUS_IDLE && take && !hwrite;
	endsequence
	sequence s_wr_mlc_plain;
		q.wr_pend && q.wr_adr == OFS_MLC && !enh;
	endsequence

	property p_read_wait;
		s_rd_addr |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answer not after one wait state");

	property p_dtr;
		q.strap_done && !q.mlc[MLC_LOOP] |=> dtr_b == !$past(d.mlc[MLC_DTR]) || q.mlc[MLC_LOOP];
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr_b does not follow control bit 0");

	property p_loop_map;
		q.mlc[MLC_LOOP] && $stable(q.mlc) |=> q.mls[7:4] == {$past(q.mlc[3]), $past(q.mlc[2]),
			$past(q.mlc[0]), $past(q.mlc[1])};
	endproperty
	a_loop_map: assert property (p_loop_map) else $error("loopback status mapping wrong");

	property p_gate_mlc;
		s_wr_mlc_plain |=> q.mlc[7:5] == $past(q.mlc[7:5]);
	endproperty
	a_gate_mlc: assert property (p_gate_mlc) else $error("gated control bits changed");

	property p_divisor_sleep;
		q.wr_pend && q.wr_adr == OFS_DIVISOR && q.iem[IEM_SLEEP] |=> $stable(q.divisor);
	endproperty
	a_divisor_sleep: assert property (p_divisor_sleep) else $error("divisor written in sleep");

	property p_thr_reenable;
		q.wr_pend && q.wr_adr == OFS_IEM && !q.iem[IEM_TX] && hwdata[IEM_TX] && evt.tx_below |=> q.thr_pend;
	endproperty
	a_thr_reenable: assert property (p_thr_reenable) else $error("no new transmit interrupt");

	property p_id_bit0;
		rd_now && q.rd_adr == OFS_ISI |=> hrdata[0] == !$past(any_pend) && hrdata[7] == $past(q.qctl[0]);
	endproperty
	a_id_bit0: assert property (p_id_bit0) else $error("identification bit 0 or 7 wrong");

	property p_irq;
		any_pend |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt output not raised");

	property p_ls_first;
		rd_now && q.rd_adr == OFS_ISI && src_ls |=> hrdata[5:0] == ID_LS;
	endproperty
	a_ls_first: assert property (p_ls_first) else $error("line status not top priority");

	property p_ms_clear;
		rd_now && q.rd_adr == OFS_MLS && set_delta == 4'h0 |=> q.mls[3:0] == 4'h0;
	endproperty
	a_ms_clear: assert property (p_ms_clear) else $error("status deltas not cleared by read");

endmodule

// ---- umci_modem.sv ----
// behavioural model of the modem that faces the channel's control lines
`timescale 1ns/1ps
module umci_modem #(
	parameter int LAG = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] line_req,
	output logic cts_b,
	output logic dsr_b,
	output logic ri_b,
	output logic cd_b,
	output logic rx_pin
);
	// ------------------------------------------------------------
	// line delay
	// ------------------------------------------------------------
	logic [3:0] pipe [LAG];

	// a real modem answers late, so requested levels reach the pins after LAG cycles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < LAG; i++) begin
				pipe[i] <= 4'hf;
			end
		end else begin
			pipe[0] <= line_req;
			for (int i = 1; i < LAG; i++) begin
				pipe[i] <= pipe[i-1];
			end
		end
	end

	// request order is cd, ri, dsr, cts; all lines are active low and idle high
	assign {cd_b, ri_b, dsr_b, cts_b} = pipe[LAG-1];
	assign rx_pin = 1'b1; // receive line rests at mark, no frames sent
endmodule

// ---- tb.sv ----
// self-checking bench of the modem control and interrupt id block
`timescale 1ns/1ps
module tb;
	import umci_pkg::*;
	localparam int DIVS = 4;
	typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} umci_row_s;
	logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, pin, tx_serial, rx_pin, rx_serial;
	logic cts_b, dsr_b, ri_b, cd_b, dtr_b, rts_b, auto_rts_en, hw_rts_b, irq, irq_oe, tick_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [3:0] line_req;
	umci_evt_s evt;
	umci_cfg_s cfg;
	int err_total, total_checks, cyc, ticks;
	// ------------------------------------------------------------
	// ordinary register cases: write, then read back
	// ------------------------------------------------------------
	umci_row_s rows [14] = '{
		'{OFS_MLC, 32'h0b, OFS_MLC, 32'h8b}, '{OFS_IEM, 32'hf0, OFS_IEM, 32'h00},
		'{OFS_MLC, 32'h6b, OFS_MLC, 32'h8b}, '{OFS_DIVISOR, 32'h1234, OFS_DIVISOR, 32'h1234},
		'{OFS_EFC, 32'h10, OFS_EFC, 32'h10}, '{OFS_THRESH, 32'h5a, OFS_THRESH, 32'h00},
		'{OFS_MLC, 32'h6f, OFS_MLC, 32'h6f}, '{OFS_THRESH, 32'h5a, OFS_THRESH, 32'h5a},
		'{OFS_TRIG, 32'h3c, OFS_TRIG, 32'h3c}, '{OFS_IEM, 32'hf0, OFS_IEM, 32'hf0},
		'{OFS_DIVISOR, 32'h55, OFS_DIVISOR, 32'h1234}, '{OFS_ISI, 32'hff, OFS_ISI, 32'h01},
		'{8'h40, 32'ha5, 8'h40, 32'h00}, '{OFS_QCTL, 32'h01, OFS_ISI, 32'hc1}};

	umci_core #(.DIV_SLOW(DIVS)) dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .cts_b(cts_b), .dsr_b(dsr_b), .ri_b(ri_b), .cd_b(cd_b),
		.dtr_b(dtr_b), .rts_b(rts_b), .auto_rts_en(auto_rts_en), .hw_rts_b(hw_rts_b),
		.clock_divide_select_pin(pin), .tx_serial(tx_serial), .rx_pin(rx_pin), .rx_serial(rx_serial),
		.evt(evt), .cfg(cfg), .irq(irq), .irq_oe(irq_oe), .tick_en(tick_en));
	umci_modem #(.LAG(2)) modem (.clk(clk), .rst_b(rst_b), .line_req(line_req), .cts_b(cts_b),
		.dsr_b(dsr_b), .ri_b(ri_b), .cd_b(cd_b), .rx_pin(rx_pin));
	assign hready = hreadyout; // single slave drives the bus ready

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// sampling at the falling edge sees what the master samples at the next rising edge, without a race
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do begin
			@(negedge clk);
			rdy = hreadyout;
			@(posedge clk);
		end while (rdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(negedge clk);
			rdy = hreadyout;
			rd = hrdata;
			@(posedge clk);
		end while (rdy !== 1'b1);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
		xfer(1'b0, a, 32'h0);
		chk(rd, ex);
	endtask
	task automatic ident(input logic [7:0] ex);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(irq, !ex[0]);
		@(posedge clk);
		rchk(OFS_ISI, ex);
	endtask
	task automatic ms_step(input logic [3:0] l, input logic [7:0] exid, input logic [7:0] exst);
		line_req <= l;
		ident(exid);
		rchk(OFS_MLS, exst);
	endtask
	task automatic count_ticks(input int ex);
		ticks = 0;
		repeat (8) begin
			@(negedge clk);
			if (tick_en === 1'b1) ticks++;
		end
		@(posedge clk);
		chk(ticks, ex);
	endtask
	task automatic do_reset(input logic p);
		pin <= p;
		rst_b <= 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
	endtask
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// the whole run needs about 330 cycles, so this only fires on a hang
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk);
			cyc++;
			if (cyc == 20000) begin
				err_total++;
				end_sim();
			end
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{auto_rts_en, hw_rts_b, tx_serial, pin, rst_b} = 5'b01100;
		line_req = 4'hf;
		evt = '0;
		hsel = 1'b1;
		do_reset(1'b0);
		rchk(OFS_MLC, 32'h80);
		chk({dtr_b, rts_b, irq_oe, irq, hresp}, 5'b11000);
		rchk(OFS_ISI, 32'h01);
		rchk(OFS_MLS, 32'h00);
		count_ticks(8 / DIVS);
		$display("test reset done");
		foreach (rows[i]) begin
			xfer(1'b1, rows[i].wa, rows[i].wd);
			rchk(rows[i].ra, rows[i].ex);
		end
		chk({dtr_b, rts_b, irq_oe}, 3'b001);
		chk({cfg.xon_any, cfg.queue_ready_en, cfg.thresh_access}, 3'b111);
		chk({cfg.sleep_en, cfg.fifo_en}, 2'b11);
		chk({cfg.thresh, cfg.trig, cfg.divisor}, 32'h5a3c1234);
		$display("test table done");
		// modem lines: cts, ring, dsr and cd transitions, interrupt cleared by status read
		tx_serial <= 1'b0;
		xfer(1'b1, OFS_IEM, 32'hf8);
		ms_step(4'b1110, 8'hc8, 8'h11);
		ms_step(4'b1111, 8'hc8, 8'h01);
		ms_step(4'b1111, 8'he0, 8'h00);
		// ring going active sets no delta, only its release does
		ms_step(4'b1011, 8'hc1, 8'h40);
		ms_step(4'b1111, 8'hc8, 8'h04);
		ms_step(4'b0101, 8'hc8, 8'haa);
		ms_step(4'b1111, 8'hc8, 8'h0a);
		ms_step(4'b1111, 8'hc1, 8'h00);
		chk(rx_serial, 1'b1);
		$display("test modem done");
		// priority: line error, timeout, receive, transmit, xoff, then nothing
		xfer(1'b1, OFS_IEM, 32'hff);
		evt <= 5'b11111;
		@(posedge clk);
		evt <= 5'b11110;
		ident(8'hc6);
		evt <= 5'b01110;
		ident(8'hcc);
		evt <= 5'b00110;
		ident(8'hc4);
		evt <= 5'b00010;
		ident(8'hc2);
		ident(8'hd0);
		ident(8'hc1);
		xfer(1'b1, OFS_IEM, 32'hfd);
		xfer(1'b1, OFS_IEM, 32'hff);
		ident(8'hc2);
		ident(8'hc1);
		evt <= 5'b00000;
		xfer(1'b1, OFS_MLC, 32'h6d);
		ident(8'he0);
		ident(8'hc1);
		$display("test priority done");
		// automatic flow control takes the request line, its release flags a rise
		auto_rts_en <= 1'b1;
		hw_rts_b <= 1'b0;
		repeat (3) @(posedge clk);
		chk(rts_b, 1'b0);
		auto_rts_en <= 1'b0;
		hw_rts_b <= 1'b1;
		// request line driven low again before the read: the read must still clear the rise flag
		xfer(1'b1, OFS_MLC, 32'h6f);
		ident(8'he0);
		ident(8'hc1);
		$display("test auto request done");
		// loopback: control bits feed status, transmit feeds receive
		xfer(1'b1, OFS_MLC, 32'h7f);
		xfer(1'b0, OFS_MLS, 32'h0);
		chk(rd[7:4], 4'hf);
		chk({dtr_b, rts_b, cfg.loopback, rx_serial}, 4'b1110);
		tx_serial <= 1'b1;
		repeat (3) @(posedge clk);
		chk(rx_serial, 1'b1);
		xfer(1'b1, OFS_MLC, 32'h7d);
		xfer(1'b0, OFS_MLS, 32'h0);
		chk(rd[7:4], 4'he);
		$display("test loopback done");
		// second reset with the select pin high
		do_reset(1'b1);
		rchk(OFS_MLC, 32'h00);
		chk({cfg.thresh, cfg.trig, cfg.divisor}, 32'h0);
		count_ticks(8);
		$display("test second reset done");
		end_sim();
	end
endmodule
